// [logic/ppg_ecg_acquisition_config.sv]
// Acquisition configuration: LED pulse, averaging, proximity start, LED currents, ECG rate
//
// Functional notes
// - Pulse-width code picks 50/100/200/400 us
// - Integration equals pulse; 19-bit conversions
// - Average 1..16, codes 101-111 give 32
// - Per-channel averaging, one result per group
// - Threshold compared with IR count's top byte
// - Threshold reached: interrupt, start optical mode
// - Threshold 0xFF fires only on saturation
// - IR current is code times range step
// - Red current is code times range step
// - Range 00 is 50 mA, 01 100 mA
// - Pilot amplitude in proximity and multi-LED
// - Pilot current uses that LED's range
// - Clock bit and OSR pick ECG rate
// - Unsupported optical rate clamps to highest supported
`timescale 1ns/1ps
module ppg_ecg_acquisition_config #(
  parameter int PULSE_BASE = pea_pkg::PULSE_BASE_CYCLES
) (
  input  wire logic                    core_clk,
  input  wire logic                    rstn,
  input  wire pea_pkg::pea_reg_req_type regReq,
  output logic [7:0]                   regRdData,
  output logic                         regRdValid,
  input  wire pea_pkg::pea_sample_type sampleIn,
  input  wire logic                    convStart,
  input  wire logic                    proxModeEnable,
  input  wire logic                    multiLedPilot,
  input  wire logic                    twoLedMode,
  output logic                         ledDrive,
  output logic                         adcIntegrate,
  output pea_pkg::pea_sample_type      fifoPush,
  output logic                         proxIrq,
  output logic                         opticalStart,
  output logic                         acquireActive,
  output logic [9:0]                   irCurrentSteps,
  output logic [9:0]                   redCurrentSteps,
  output logic [11:0]                  ecgSampleRate
);

  typedef struct packed {
    logic [7:0]                      optCfg;
    logic [7:0]                      avgCfg;
    logic [7:0]                      proxThr;
    logic [7:0]                      irAmp;
    logic [7:0]                      redAmp;
    logic [7:0]                      range;
    logic [7:0]                      pilotAmp;
    logic [7:0]                      ecgCfg;
    logic [7:0]                      rdData;
    logic                            rdValid;
    logic [pea_pkg::TIMER_W-1:0]     pulseCnt;
    logic                            pulseOn;
    pea_pkg::pea_mode_type           mode;
    pea_pkg::pea_sample_type         push;
    logic                            irq;
    logic                            start;
    logic [9:0]                      irSteps;
    logic [9:0]                      redSteps;
    logic [11:0]                     ecgRate;
    logic                            acqActive;
  } pea_top_state_type;

  pea_top_state_type state;
  pea_top_state_type next_state;

  // Highest supported rate code for pulse width and LED count.
  // Two-pulse codes keep two-pulse ceilings
  // so a request never drops to one pulse
  function automatic logic [3:0] clampRate(input logic [3:0] req, input logic [1:0] pw, input logic two);
    logic [3:0] ceilN1;
    logic [3:0] ceilN2;
    ceilN1 = pea_pkg::SR_1000;
    unique case (pw)
      2'h0: ceilN1 = two ? pea_pkg::SR_1600 : pea_pkg::SR_3200;
      2'h1: ceilN1 = two ? pea_pkg::SR_800 : pea_pkg::SR_1600;
      2'h2: ceilN1 = two ? pea_pkg::SR_800 : pea_pkg::SR_1000;
      2'h3: ceilN1 = two ? pea_pkg::SR_400 : pea_pkg::SR_1000;
    endcase
    ceilN2 = (two && pw == pea_pkg::PW_400) ? pea_pkg::SR_N2_84 : pea_pkg::SR_N2_100;
    if (req <= pea_pkg::SR_N1_LAST)
      clampRate = (req > ceilN1) ? ceilN1 : req;
    else
      clampRate = (req > ceilN2) ? ceilN2 : req;
  endfunction : clampRate

  // Averaging code to shift count
  // Codes 101 to 111 saturate at 32 samples
  function automatic logic [2:0] avgShift(input logic [2:0] code);
    avgShift = (code >= pea_pkg::AVG_CODE_CAP) ? pea_pkg::AVG_CODE_CAP : code;
  endfunction : avgShift

  // ECG sample rate in samples per second
  // Typical rates only; the real rate
  // follows the converter clock
  function automatic logic [11:0] ecgRateOf(input logic [2:0] sel);
    ecgRateOf = 12'd1600;
    unique case (sel)
      3'h0: ecgRateOf = 12'd1600;
      3'h1: ecgRateOf = 12'd800;
      3'h2: ecgRateOf = 12'd400;
      3'h3: ecgRateOf = 12'd200;
      3'h4: ecgRateOf = 12'd3200;
      3'h5: ecgRateOf = 12'd1600;
      3'h6: ecgRateOf = 12'd800;
      3'h7: ecgRateOf = 12'd400;
    endcase
  endfunction : ecgRateOf

  // Decoded fields and averager results
  logic [1:0]  pulseWidthCode;
  logic [2:0]  shiftSel;
  logic        avgRestart;
  logic [1:0]  avgValid;
  logic [pea_pkg::ADC_BITS-1:0] avgData [2];
  logic        usePilot;
  logic [7:0]  irCode;
  logic [7:0]  redCode;
  logic [9:0]  irStepsComb;
  logic [9:0]  redStepsComb;
  logic [7:0]  irTop;
  logic        irSaturated;
  logic        proxHit;

  assign pulseWidthCode = state.optCfg[pea_pkg::PW_LSB +: 2];
  // codes above 4 all give 32
  assign shiftSel = avgShift(state.avgCfg[2:0]);
  // Rewriting the count drops both partial
  // groups; no mean mixes two sizes
  assign avgRestart = regReq.wrEn && (regReq.addr == pea_pkg::ADDR_AVG_CFG);

  // one averager per channel
  // Each sees only its own channel's samples
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1)
    begin : gAvg
      pea_channel_avg #(
        .DATA_W    (pea_pkg::ADC_BITS),
        .SHIFT_MAX (pea_pkg::AVG_MAX_SHIFT)
      ) uAvg (
        .core_clk    (core_clk),
        .rstn        (rstn),
        .restart     (avgRestart),
        .shiftSel    (shiftSel),
        .sampleValid (sampleIn.valid && (sampleIn.channel == 1'(ch))),
        .sampleData  (sampleIn.data),
        .resultValid (avgValid[ch]),
        .resultData  (avgData[ch])
      );
    end
  endgenerate

  // pilot amplitude while watching or in multi-LED slots
  // Both LEDs take pilot; ranges stay per LED
  assign usePilot = (state.mode == pea_pkg::MODE_WATCH) || multiLedPilot;
  assign irCode   = usePilot ? state.pilotAmp : state.irAmp;
  assign redCode  = usePilot ? state.pilotAmp : state.redAmp;

  // each LED keeps its own range with the pilot code
  pea_led_current uIrCurrent (
    .ampCode      (irCode),
    .rangeCode    (state.range[pea_pkg::IR_RANGE_LSB +: 2]),
    .currentSteps (irStepsComb)
  );

  // Red twin of the IR current path
  pea_led_current uRedCurrent (
    .ampCode      (redCode),
    .rangeCode    (state.range[pea_pkg::RED_RANGE_LSB +: 2]),
    .currentSteps (redStepsComb)
  );

  // top byte of the IR count against threshold
  // Threshold zero matches any IR sample
  assign irTop       = sampleIn.data[pea_pkg::ADC_BITS-1 -: pea_pkg::THR_BITS];
  assign irSaturated = &sampleIn.data;
  // full-scale threshold needs a saturated count
  assign proxHit = sampleIn.valid && (sampleIn.channel == pea_pkg::CH_IR) &&
                   ((state.proxThr == pea_pkg::PROX_SAT_THR) ? irSaturated : (irTop >= state.proxThr));

  // One record, one comb process, one register
  // Next-state logic
  always_comb
  begin
    next_state = state;
    next_state.rdValid = 1'b0;
    next_state.irq     = 1'b0;
    next_state.start   = 1'b0;
    next_state.push    = '0;

    // writes keep only implemented bits
    // Same-clock read sees the old value
    if (regReq.wrEn)
    begin
      unique case (regReq.addr)
        pea_pkg::ADDR_OPT_CFG:   next_state.optCfg   = regReq.wrData;
        pea_pkg::ADDR_AVG_CFG:   next_state.avgCfg   = regReq.wrData & pea_pkg::AVG_MASK;
        pea_pkg::ADDR_PROX_THR:  next_state.proxThr  = regReq.wrData;
        pea_pkg::ADDR_IR_AMP:    next_state.irAmp    = regReq.wrData;
        pea_pkg::ADDR_RED_AMP:   next_state.redAmp   = regReq.wrData;
        pea_pkg::ADDR_RANGE:     next_state.range    = regReq.wrData & pea_pkg::RANGE_MASK;
        pea_pkg::ADDR_PILOT_AMP: next_state.pilotAmp = regReq.wrData;
        pea_pkg::ADDR_ECG_CFG:   next_state.ecgCfg   = regReq.wrData & pea_pkg::ECG_MASK;
        default:                 next_state.optCfg   = state.optCfg;
      endcase
    end

    // rate is re-clamped every cycle, so LED-mode changes apply too
    // Read-back shows the code in force
    next_state.optCfg[pea_pkg::SR_LSB +: 4] = clampRate(next_state.optCfg[pea_pkg::SR_LSB +: 4],
                                                        next_state.optCfg[pea_pkg::PW_LSB +: 2], twoLedMode);

    if (regReq.rdEn)
    begin
      next_state.rdValid = 1'b1;
      unique case (regReq.addr)
        pea_pkg::ADDR_OPT_CFG:   next_state.rdData = state.optCfg;
        pea_pkg::ADDR_AVG_CFG:   next_state.rdData = state.avgCfg;
        pea_pkg::ADDR_PROX_THR:  next_state.rdData = state.proxThr;
        pea_pkg::ADDR_IR_AMP:    next_state.rdData = state.irAmp;
        pea_pkg::ADDR_RED_AMP:   next_state.rdData = state.redAmp;
        pea_pkg::ADDR_RANGE:     next_state.rdData = state.range;
        pea_pkg::ADDR_PILOT_AMP: next_state.rdData = state.pilotAmp;
        pea_pkg::ADDR_ECG_CFG:   next_state.rdData = state.ecgCfg;
        default:                 next_state.rdData = pea_pkg::CFG_RESET;
      endcase
    end

    // pulse length doubles per code; start ignored while a pulse runs
    // Loads N-1; the clearing clock ends it: N high
    // A start during a pulse is dropped
    if (state.pulseOn)
    begin
      if (state.pulseCnt == '0)
        next_state.pulseOn = 1'b0;
      else
        next_state.pulseCnt = state.pulseCnt - pea_pkg::TIMER_W'(1);
    end
    else if (convStart)
    begin
      next_state.pulseOn  = 1'b1;
      next_state.pulseCnt = pea_pkg::TIMER_W'((PULSE_BASE << pulseWidthCode) - 1);
    end

    // Proximity watch and acquisition sequencing
    // Enable low returns to idle from any state;
    // hits outside watch are ignored
    unique case (state.mode)
      pea_pkg::MODE_IDLE:
      begin
        if (proxModeEnable)
          next_state.mode = pea_pkg::MODE_WATCH;
      end
      pea_pkg::MODE_WATCH:
      begin
        if (!proxModeEnable)
          next_state.mode = pea_pkg::MODE_IDLE;
        // interrupt and start the configured optical mode
        else if (proxHit)
        begin
          next_state.irq   = 1'b1;
          next_state.start = 1'b1;
          next_state.mode  = pea_pkg::MODE_ACQUIRE;
        end
      end
      pea_pkg::MODE_ACQUIRE:
      begin
        if (!proxModeEnable)
          next_state.mode = pea_pkg::MODE_IDLE;
      end
      default: next_state.mode = pea_pkg::MODE_IDLE;
    endcase

    // push one averaged result; results that come out while watching are not stored
    // IR wins a tie, which one sample per clock rules out
    if (state.mode != pea_pkg::MODE_WATCH)
    begin
      if (avgValid[pea_pkg::CH_IR])
      begin
        next_state.push.valid   = 1'b1;
        next_state.push.channel = pea_pkg::CH_IR;
        next_state.push.data    = avgData[pea_pkg::CH_IR];
      end
      else if (avgValid[pea_pkg::CH_RED])
      begin
        next_state.push.valid   = 1'b1;
        next_state.push.channel = pea_pkg::CH_RED;
        next_state.push.data    = avgData[pea_pkg::CH_RED];
      end
    end

    next_state.irSteps  = irStepsComb;
    next_state.redSteps = redStepsComb;
    // ECG rate from clock bit and OSR
    next_state.ecgRate  = ecgRateOf(state.ecgCfg[pea_pkg::ECG_CLK_BIT:0]);

    // Own flop so the pin comes from a register
    next_state.acqActive = (next_state.mode == pea_pkg::MODE_ACQUIRE);
  end

  // State register, all fields zero at reset
  // but mode is idle and the ECG rate shows the code-zero rate
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      state         <= '0;
      state.mode    <= pea_pkg::MODE_IDLE;
      state.ecgRate <= ecgRateOf(3'h0);
    end
    else
      state <= next_state;
  end

  // Each output below is a plain state flop
  assign regRdData       = state.rdData;
  assign regRdValid      = state.rdValid;
  assign ledDrive        = state.pulseOn;
  // integration window is the LED pulse itself
  // One flop feeds both pins; they cannot drift
  assign adcIntegrate    = state.pulseOn;
  assign fifoPush        = state.push;
  assign proxIrq         = state.irq;
  assign opticalStart    = state.start;
  assign acquireActive   = state.acqActive;
  assign irCurrentSteps  = state.irSteps;
  assign redCurrentSteps = state.redSteps;
  assign ecgSampleRate   = state.ecgRate;

endmodule : ppg_ecg_acquisition_config

// [include/pea_pkg.sv]
// Shared constants, types and register map of the optical/ECG acquisition config block
package pea_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_OPT_CFG   = 8'h0E;
  localparam logic [7:0] ADDR_AVG_CFG   = 8'h0F;
  localparam logic [7:0] ADDR_PROX_THR  = 8'h10;
  localparam logic [7:0] ADDR_IR_AMP    = 8'h11;
  localparam logic [7:0] ADDR_RED_AMP   = 8'h12;
  localparam logic [7:0] ADDR_RANGE     = 8'h14;
  localparam logic [7:0] ADDR_PILOT_AMP = 8'h15;
  localparam logic [7:0] ADDR_ECG_CFG   = 8'h3C;

  // Reset value and implemented-bit masks
  localparam logic [7:0] CFG_RESET  = 8'h00;
  localparam logic [7:0] AVG_MASK   = 8'h07;
  localparam logic [7:0] RANGE_MASK = 8'h0F;
  localparam logic [7:0] ECG_MASK   = 8'h07;

  // Field positions
  localparam int PW_LSB        = 0;
  localparam int SR_LSB        = 2;
  localparam int IR_RANGE_LSB  = 0;
  localparam int RED_RANGE_LSB = 2;
  localparam int ECG_CLK_BIT   = 2;

  // Converter and averaging figures
  localparam int         ADC_BITS      = 19;
  localparam int         THR_BITS      = 8;
  localparam int         AVG_MAX_SHIFT = 5;
  localparam logic [2:0] AVG_CODE_CAP  = 3'h5;
  localparam logic [7:0] PROX_SAT_THR  = 8'hFF;

  // Timing: shortest LED pulse, doubled per pulse-width code
  localparam longint CLK_HZ            = 25000000;
  localparam longint PULSE_BASE_US     = 50;
  localparam int     PULSE_BASE_CYCLES = int'((PULSE_BASE_US * CLK_HZ + 64'd999999) / 64'd1000000);
  localparam int     TIMER_W           = 16;

  // Optical sample-rate codes used as ceilings
  localparam logic [3:0] SR_3200    = 4'hA;
  localparam logic [3:0] SR_1600    = 4'h9;
  localparam logic [3:0] SR_1000    = 4'h8;
  localparam logic [3:0] SR_800     = 4'h7;
  localparam logic [3:0] SR_400     = 4'h6;
  localparam logic [3:0] SR_N1_LAST = 4'hA;
  localparam logic [3:0] SR_N2_100  = 4'hF;
  localparam logic [3:0] SR_N2_84   = 4'hE;
  localparam logic [1:0] PW_400     = 2'h3;

  localparam logic CH_IR  = 1'b0;
  localparam logic CH_RED = 1'b1;

  typedef enum logic [2:0] {
    MODE_IDLE    = 3'b001,
    MODE_WATCH   = 3'b010,
    MODE_ACQUIRE = 3'b100
  } pea_mode_type;

  typedef struct packed {
    logic                valid;
    logic                channel;
    logic [ADC_BITS-1:0] data;
  } pea_sample_type;

  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
  } pea_reg_req_type;

endpackage : pea_pkg

// [logic/pea_channel_avg.sv]
// Per-channel sample averager with decimation
`timescale 1ns/1ps
module pea_channel_avg #(
  parameter int DATA_W    = 19,
  parameter int SHIFT_MAX = 5
) (
  input  wire logic              core_clk,
  input  wire logic              rstn,
  input  wire logic              restart,
  input  wire logic [2:0]        shiftSel,
  input  wire logic              sampleValid,
  input  wire logic [DATA_W-1:0] sampleData,
  output logic                   resultValid,
  output logic [DATA_W-1:0]      resultData
);

  localparam int ACC_W = DATA_W + SHIFT_MAX;

  typedef struct packed {
    logic [ACC_W-1:0]     acc;
    logic [SHIFT_MAX-1:0] cnt;
    logic                 valid;
    logic [DATA_W-1:0]    data;
  } pea_avg_state_type;

  pea_avg_state_type state;
  pea_avg_state_type next_state;

  // Accumulate, then emit the mean and start a fresh group
  always_comb
  begin
    logic [ACC_W-1:0]     sum;
    logic [SHIFT_MAX-1:0] last;
    sum = state.acc + ACC_W'(sampleData);
    last = SHIFT_MAX'((1 << shiftSel) - 1);
    next_state = state;
    next_state.valid = 1'b0;
    if (restart)
    begin
      // A new count must not mix with a half-built group
      next_state.acc = '0;
      next_state.cnt = '0;
    end
    else if (sampleValid)
    begin
      if (state.cnt == last)
      begin
        next_state.data  = DATA_W'(sum >> shiftSel);
        next_state.valid = 1'b1;
        next_state.acc   = '0;
        next_state.cnt   = '0;
      end
      else
      begin
        next_state.acc = sum;
        next_state.cnt = state.cnt + SHIFT_MAX'(1);
      end
    end
  end

  // State register
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      state <= '0;
    else
      state <= next_state;
  end

  assign resultValid = state.valid;
  assign resultData  = state.data;

endmodule : pea_channel_avg

// [logic/pea_led_current.sv]
// LED current in 0.2 mA steps from amplitude code and range
`timescale 1ns/1ps
module pea_led_current (
  input  wire logic [7:0] ampCode,
  input  wire logic [1:0] rangeCode,
  output logic [9:0]      currentSteps
);

  // step size per range, code zero gives zero
  // range 01 doubles the step; 10 and 11 fall back to the 50 mA range
  always_comb
  begin
    if (rangeCode == 2'h1)
      currentSteps = {1'b0, ampCode, 1'b0};
    else
      currentSteps = {2'h0, ampCode};
  end

endmodule : pea_led_current

// [testbench/pea_host_model.sv]
// Host model driving the byte register port of the acquisition block
`timescale 1ns/1ps
module pea_host_model (
  input  wire logic                core_clk,
  output pea_pkg::pea_reg_req_type regReq,
  input  wire logic [7:0]          regRdData,
  input  wire logic                regRdValid
);
  initial regReq = '0;

  // One byte write; released fields show the inverse so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    regReq.wrEn = 1'b1;
    regReq.addr = a;
    regReq.wrData = d;
    @(posedge core_clk);
    #1;
    regReq.wrEn = 1'b0;
    regReq.addr = ~a;
    regReq.wrData = ~d;
  endtask : wr

  // One byte read; answer taken one cycle after the request edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1;
    regReq.rdEn = 1'b1;
    regReq.addr = a;
    @(posedge core_clk);
    #1;
    regReq.rdEn = 1'b0;
    regReq.addr = ~a;
    d = (regRdValid === 1'b1) ? regRdData : 8'hXX;
  endtask : rd
endmodule : pea_host_model

// [testbench/pea_assertions.sv]
// Port-level assertions for the acquisition config block
`timescale 1ns/1ps
module pea_assertions #(
  parameter int PULSE_BASE = 4
) (
  input wire logic                     core_clk,
  input wire logic                     rstn,
  input wire pea_pkg::pea_reg_req_type regReq,
  input wire logic                     regRdValid,
  input wire pea_pkg::pea_sample_type  sampleIn,
  input wire logic                     convStart,
  input wire logic                     proxModeEnable,
  input wire logic                     ledDrive,
  input wire logic                     adcIntegrate,
  input wire pea_pkg::pea_sample_type  fifoPush,
  input wire logic                     proxIrq,
  input wire logic                     opticalStart,
  input wire logic                     acquireActive
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  logic [15:0] highCnt;
  logic [15:0] next_highCnt;

  // Pulse length counter; a counter keeps long pulses cheap for the tools
  always_comb next_highCnt = ledDrive ? highCnt + 16'h0001 : 16'h0000;
  always_ff @(posedge core_clk) highCnt <= rstn ? next_highCnt : 16'h0000;

  a_read_answer: assert property (regReq.rdEn |=> regRdValid)
    else $error("read answer missing");
  a_read_cause: assert property (regRdValid |-> $past(regReq.rdEn))
    else $error("read answer without request");
  a_pulse_start: assert property (convStart && !ledDrive |=> ledDrive)
    else $error("pulse did not start");
  a_pulse_len: assert property ($fell(ledDrive) |-> (highCnt == PULSE_BASE ||
    highCnt == 2 * PULSE_BASE || highCnt == 4 * PULSE_BASE || highCnt == 8 * PULSE_BASE))
    else $error("pulse length wrong");
  a_integrate_match: assert property (adcIntegrate == ledDrive)
    else $error("integration differs from pulse");
  a_irq_pair: assert property (proxIrq |-> opticalStart && acquireActive ##1 !proxIrq)
    else $error("interrupt without start");
  a_start_pair: assert property (opticalStart |-> proxIrq)
    else $error("start without interrupt");
  a_irq_cause: assert property (proxIrq |-> $past(sampleIn.valid && sampleIn.channel == pea_pkg::CH_IR))
    else $error("interrupt without infrared sample");
  a_idle_quiet: assert property (!proxModeEnable |=> !acquireActive)
    else $error("acquisition while proximity off");
  a_push_cause: assert property (fifoPush.valid |-> $past(sampleIn.valid, 2))
    else $error("push without sample");

  c_irq: cover property (proxIrq);
  c_push: cover property (fifoPush.valid);
  c_pulse: cover property ($fell(ledDrive));
endmodule : pea_assertions

bind ppg_ecg_acquisition_config pea_assertions #(.PULSE_BASE(PULSE_BASE)) pea_assertions_i (
  .core_clk(core_clk), .rstn(rstn), .regReq(regReq), .regRdValid(regRdValid), .sampleIn(sampleIn),
  .convStart(convStart), .proxModeEnable(proxModeEnable), .ledDrive(ledDrive), .adcIntegrate(adcIntegrate),
  .fifoPush(fifoPush), .proxIrq(proxIrq), .opticalStart(opticalStart), .acquireActive(acquireActive));

// [testbench/tb_top.sv]
// Self-checking bench for the acquisition config block
`timescale 1ns/1ps
module tb_top;
  localparam int PB = 4;
  localparam logic [7:0] RA [7] = '{8'h0F, 8'h10, 8'h11, 8'h12, 8'h14, 8'h15, 8'h3C};
  localparam logic [7:0] RM [7] = '{8'h07, 8'hFF, 8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'h07};
  logic                     core_clk = 1'b0;
  logic                     rstn = 1'b0;
  logic                     convStart = 1'b0;
  logic                     proxModeEnable = 1'b0;
  logic                     multiLedPilot = 1'b0;
  logic                     twoLedMode = 1'b0;
  pea_pkg::pea_sample_type  sampleIn = '0;
  pea_pkg::pea_reg_req_type regReq;
  pea_pkg::pea_sample_type  fifoPush;
  pea_pkg::pea_sample_type  pushQ [$];
  logic [7:0]               regRdData;
  logic                     regRdValid, ledDrive, adcIntegrate, proxIrq, opticalStart, acquireActive;
  logic [9:0]               irCurrentSteps, redCurrentSteps;
  logic [11:0]              ecgSampleRate;
  int                       fails = 0;
  int                       check_count = 0;
  int                       irqCnt = 0;

  always #20 core_clk = ~core_clk;

  ppg_ecg_acquisition_config #(.PULSE_BASE(PB)) ppg_ecg_acquisition_config_i (
    .core_clk(core_clk), .rstn(rstn), .regReq(regReq), .regRdData(regRdData), .regRdValid(regRdValid),
    .sampleIn(sampleIn), .convStart(convStart), .proxModeEnable(proxModeEnable),
    .multiLedPilot(multiLedPilot), .twoLedMode(twoLedMode), .ledDrive(ledDrive), .adcIntegrate(adcIntegrate),
    .fifoPush(fifoPush), .proxIrq(proxIrq), .opticalStart(opticalStart), .acquireActive(acquireActive),
    .irCurrentSteps(irCurrentSteps), .redCurrentSteps(redCurrentSteps), .ecgSampleRate(ecgSampleRate));

  pea_host_model host_i (.core_clk(core_clk), .regReq(regReq), .regRdData(regRdData), .regRdValid(regRdValid));

  // Collect averaged results and interrupt pulses
  always @(posedge core_clk)
  begin
    if (fifoPush.valid === 1'b1)
      pushQ.push_back(fifoPush);
    if (proxIrq === 1'b1)
      irqCnt++;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host_i.rd(a, d);
    chk(d, exp);
  endtask : rchk

  // Caller lowers valid afterwards, so back-to-back samples never double-assign
  task automatic smp(input logic ch, input logic [18:0] d);
    sampleIn = {1'b1, ch, d};
    cyc(1);
  endtask : smp

  // Current in 0.2 mA units: range 01 doubles the step
  function automatic logic [9:0] cur(input logic [7:0] c, input logic big);
    return big ? {1'b0, c, 1'b0} : {2'b00, c};
  endfunction : cur

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // Watchdog well beyond the few hundred cycles the tests need
  initial
  begin
    repeat (20000) @(posedge core_clk);
    fails++;
    $display("ERROR %0t: watchdog expired", $time);
    wrap_up();
  end

  initial
  begin
    logic [7:0]  a, b, pl, r, t, v;
    logic [18:0] d;
    logic [31:0] sIr, sRd;
    int          k, n;
    void'($urandom(32'h55AC));
    repeat (2) @(posedge core_clk);
    #1;
    rstn = 1'b1;
    chk(ecgSampleRate, 12'h640);
    // Reset values, read-back with reserved bits, unmapped place
    for (int i = 0; i < 7; i++)
      rchk(RA[i], 8'h00);
    for (int i = 0; i < 7; i++)
    begin
      v = 8'($urandom);
      // range fields kept to defined codes
      if (i == 4) v = v & 8'hF5;
      host_i.wr(RA[i], v);
      rchk(RA[i], v & RM[i]);
    end
    host_i.wr(8'h13, 8'hA5);
    rchk(8'h13, 8'h00);
    $display("register test done");
    for (int c = 0; c < 8; c++)
    begin
      host_i.wr(pea_pkg::ADDR_ECG_CFG, 8'(c));
      cyc(2);
      chk(ecgSampleRate, (c[2] ? 32'hC80 : 32'h640) >> c[1:0]);
    end
    $display("ecg rate test done");
    // Amplitudes and ranges, normal and pilot, with zero and full codes
    for (int i = 0; i < 6; i++)
    begin
      a = (i == 0) ? 8'h00 : 8'($urandom);
      b = (i == 0) ? 8'hFF : 8'($urandom);
      pl = 8'($urandom);
      r = 8'($urandom) & 8'h05;
      multiLedPilot = i[0];
      host_i.wr(pea_pkg::ADDR_IR_AMP, a);
      host_i.wr(pea_pkg::ADDR_RED_AMP, b);
      host_i.wr(pea_pkg::ADDR_RANGE, r);
      host_i.wr(pea_pkg::ADDR_PILOT_AMP, pl);
      cyc(2);
      chk(irCurrentSteps, cur(i[0] ? pl : a, r[0]));
      chk(redCurrentSteps, cur(i[0] ? pl : b, r[2]));
    end
    multiLedPilot = 1'b0;
    $display("current test done");
    // Start held two cycles: the second request lands mid-pulse and is ignored
    for (int p = 0; p < 4; p++)
    begin
      host_i.wr(pea_pkg::ADDR_OPT_CFG, 8'(p));
      convStart = 1'b1;
      cyc(2);
      convStart = 1'b0;
      n = 1;
      while (ledDrive === 1'b1 && n < 999)
      begin
        n++;
        cyc(1);
      end
      chk(n, PB << p);
    end
    twoLedMode = 1'b1;
    host_i.wr(pea_pkg::ADDR_OPT_CFG, 8'h2B);
    rchk(pea_pkg::ADDR_OPT_CFG, 8'h1B);
    twoLedMode = 1'b0;
    host_i.wr(pea_pkg::ADDR_OPT_CFG, 8'h28);
    rchk(pea_pkg::ADDR_OPT_CFG, 8'h28);
    $display("pulse test done");
    // Interleaved channels for every averaging code
    for (int c = 0; c < 8; c++)
    begin
      k = (c > 5) ? 5 : c;
      host_i.wr(pea_pkg::ADDR_AVG_CFG, 8'(c));
      sIr = '0;
      sRd = '0;
      pushQ.delete();
      for (int i = 0; i < (1 << k); i++)
      begin
        d = 19'($urandom);
        smp(pea_pkg::CH_IR, d);
        sIr += d;
        d = 19'($urandom);
        smp(pea_pkg::CH_RED, d);
        sRd += d;
      end
      sampleIn.valid = 1'b0;
      cyc(4);
      chk(pushQ.size(), 2);
      chk(pushQ[0], {1'b1, pea_pkg::CH_IR, 19'(sIr >> k)});
      chk(pushQ[1], {1'b1, pea_pkg::CH_RED, 19'(sRd >> k)});
    end
    $display("averaging test done");
    // Near miss, red hit, then infrared hit on the threshold
    t = 8'($urandom_range(254, 1));
    host_i.wr(pea_pkg::ADDR_PROX_THR, t);
    proxModeEnable = 1'b1;
    cyc(2);
    chk(irCurrentSteps, cur(pl, r[0]));
    irqCnt = 0;
    smp(pea_pkg::CH_IR, {t - 8'h01, 11'h7FF});
    smp(pea_pkg::CH_RED, 19'h7FFFF);
    smp(pea_pkg::CH_IR, {t, 11'h000});
    sampleIn.valid = 1'b0;
    cyc(2);
    chk(irqCnt, 1);
    chk(acquireActive, 1'b1);
    proxModeEnable = 1'b0;
    cyc(2);
    chk(acquireActive, 1'b0);
    host_i.wr(pea_pkg::ADDR_PROX_THR, 8'hFF);
    proxModeEnable = 1'b1;
    cyc(2);
    smp(pea_pkg::CH_IR, 19'h7FFFE);
    smp(pea_pkg::CH_IR, 19'h7FFFF);
    smp(pea_pkg::CH_IR, 19'h7FFFF);
    sampleIn.valid = 1'b0;
    cyc(2);
    chk(irqCnt, 2);
    $display("proximity test done");
    wrap_up();
  end
endmodule : tb_top
